// ===== logic/shp_pkg.sv
// shp_pkg: constants, state codes and the burst address list for the sensor host serial port.
// assumes a single 20 MHz core clock; all host pins arrive asynchronously.
package shp_pkg;

  localparam int CLK_HZ          = 20_000_000;
  localparam int REG_AW          = 7;
  localparam int REG_DW          = 8;
  localparam int BURST_BYTES     = 7;
  localparam int BUF_W           = BURST_BYTES * REG_DW;

  // register addresses, the burst enable value and the register reset value
  localparam logic [6:0] MOTION_ADDR     = 7'h02;
  localparam logic [6:0] DELTA_X_ADDR    = 7'h03;
  localparam logic [6:0] DELTA_Y_ADDR    = 7'h04;
  localparam logic [6:0] SURF_QUAL_ADDR  = 7'h05;
  localparam logic [6:0] SHUTTER_UP_ADDR = 7'h06;
  localparam logic [6:0] SHUTTER_LO_ADDR = 7'h07;
  localparam logic [6:0] MAX_PIXEL_ADDR  = 7'h08;
  localparam logic [6:0] IO_MODE_ADDR    = 7'h1C;
  localparam logic [7:0] BURST_ENABLE    = 8'h10;
  localparam logic [7:0] MEM_RST_VAL     = 8'h00;

  // two-wire slave address; the two select pins fill the low bits
  localparam logic [6:0] TW_ADDR_BASE    = 7'h54;

  // rising-edge counts that close each serial phase, and the index of the last burst fetch
  localparam logic [6:0] SPI_ADDR_LAST   = 7'h07;
  localparam logic [6:0] SPI_BYTE2_LAST  = 7'h0F;
  localparam logic [6:0] SPI_BURST_LAST  = 7'h3F;
  localparam logic [2:0] TW_BIT_LAST     = 3'h7;
  localparam logic [2:0] LD_BURST_LAST   = 3'h6;

  // synchroniser input order and reset levels (idle high lines reset high)
  localparam int SY_CS = 0, SY_SCLK = 1, SY_MOSI = 2, SY_SCL = 3;
  localparam int SY_SDA = 4, SY_PSEL = 5, SY_SEL0 = 6, SY_SEL1 = 7;
  localparam int SY_N = 8;
  localparam logic [7:0] SYNC_RST_VAL    = 8'h3B;

  typedef enum logic [4:0] {
    SP_IDLE  = 5'b00001,
    SP_ADDR  = 5'b00010,
    SP_WDATA = 5'b00100,
    SP_RDATA = 5'b01000,
    SP_DONE  = 5'b10000
  } shp_spi_state_t;

  typedef enum logic [8:0] {
    TW_IDLE    = 9'b000000001,
    TW_DEV     = 9'b000000010,
    TW_DEV_ACK = 9'b000000100,
    TW_REG     = 9'b000001000,
    TW_REG_ACK = 9'b000010000,
    TW_WDATA   = 9'b000100000,
    TW_W_ACK   = 9'b001000000,
    TW_RDATA   = 9'b010000000,
    TW_R_ACK   = 9'b100000000
  } shp_tw_state_t;

  // motion burst order
  function automatic logic [6:0] burst_addr(input logic [2:0] idx);
    case (idx)
      3'h0:    burst_addr = MOTION_ADDR;
      3'h1:    burst_addr = DELTA_Y_ADDR;
      3'h2:    burst_addr = DELTA_X_ADDR;
      3'h3:    burst_addr = SURF_QUAL_ADDR;
      3'h4:    burst_addr = SHUTTER_UP_ADDR;
      3'h5:    burst_addr = SHUTTER_LO_ADDR;
      default: burst_addr = MAX_PIXEL_ADDR;
    endcase
  endfunction

endpackage

// ===== logic/shp_regmem.sv
// shp_regmem: register image, one write port and one read port with registered read data.
// assumes writer and reader share CLK; reset clears every entry.
`timescale 1ns/1ps
module shp_regmem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,    // core clock
  input  wire logic          rst_n,  // synchronous reset, active low
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] waddr,  // write address
  input  wire logic [DW-1:0] wdata,  // write data
  input  wire logic          re,     // read strobe
  input  wire logic [AW-1:0] raddr,  // read address
  output logic      [DW-1:0] rdata   // read data, one cycle after re
);

  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= shp_pkg::MEM_RST_VAL;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= shp_pkg::MEM_RST_VAL;
    end else if (re) begin
      rdata <= mem_r[raddr];
    end
  end

endmodule // shp_regmem

// ===== logic/shp_host_port.sv
// shp_host_port: host register port, four-wire serial slave or two-wire bus slave.
// assumes every host pin is asynchronous to CLK and toggles no faster than one edge per 4 CLK.
// Operation
// R1 - sensor is only a slave; it never starts a transfer
// R2 - chip select high: ignore clock and data, serial output released
// R3 - chip select rising mid-transaction aborts it and resets the port
// R4 - host keeps normal delays after an abort and frames transactions with select
// R5 - write: address byte with top bit one, then data byte
// R6 - read: address byte with top bit zero, sensor returns data byte
// R7 - sample input on rising clock, change output on falling clock
// R8 - last read bit held until the next falling clock
// R9 - host pauses clock after read address so data can be fetched
// R10 - host keeps minimum gaps between consecutive commands
// R11 - writing 0x10 to register 0x1c enables burst mode
// R12 - burst read of 0x02 returns seven registers in fixed order
// R13 - host may end burst early by raising chip select
// R14 - burst data latched after address, shifted out without gaps
// R15 - after burst the port is locked until chip select resets it
// R16 - two-wire slave address chosen by two select pins
// R17 - host makes start and stop conditions
// R18 - sensor drives data line only for acknowledge or read data
// R19 - each two-wire byte followed by one acknowledge bit, zero is acknowledge
// R20 - two-wire packets are eight bits, most significant first
// R21 - device packet holds seven address bits and a read/write bit
// R22 - register packet holds increment flag and address; flag steps per byte
// R23 - host acknowledges to continue a read, not-acknowledges to finish
// R24 - port select low picks two-wire, high picks four-wire
// R25 - start recognised anywhere and abandons a partial packet
`timescale 1ns/1ps
module shp_host_port (
  input  wire logic       CLK,              // core clock, 20 MHz
  input  wire logic       RST_N,            // synchronous reset, active low
  input  wire logic       PORT_SEL,         // high four-wire, low two-wire
  input  wire logic       SERIAL_SELECT_N,  // four-wire chip select, active low
  input  wire logic       SCLK,             // four-wire clock from host
  input  wire logic       MOSI,             // four-wire data in
  output logic            MISO_O,           // four-wire data out
  output logic            MISO_OE,          // four-wire output enable
  input  wire logic       SCL,              // two-wire clock
  input  wire logic       SDA_I,            // two-wire data level
  output logic            SDA_O,            // two-wire data drive level, always low
  output logic            SDA_OE,           // two-wire pull-low enable
  input  wire logic       SLAVE_ADDR_SEL0,  // two-wire address select bit 0
  input  wire logic       SLAVE_ADDR_SEL1,  // two-wire address select bit 1
  output logic            BURST_MODE,       // motion burst enabled
  output logic            REG_WR_PULSE,     // register written, one cycle
  output logic      [6:0] REG_WR_ADDR,      // written register address
  output logic      [7:0] REG_WR_DATA       // written register data
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection

  logic [shp_pkg::SY_N-1:0] raw, meta_r, sync_r, prev_r;

  assign raw = {SLAVE_ADDR_SEL1, SLAVE_ADDR_SEL0, PORT_SEL, SDA_I, SCL, MOSI, SCLK, SERIAL_SELECT_N};

  genvar gi;
  generate
    for (gi = 0; gi < shp_pkg::SY_N; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          meta_r[gi] <= shp_pkg::SYNC_RST_VAL[gi];
          sync_r[gi] <= shp_pkg::SYNC_RST_VAL[gi];
          prev_r[gi] <= shp_pkg::SYNC_RST_VAL[gi];
        end else begin
          meta_r[gi] <= raw[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  logic cs_n_s, port_spi, spi_en, tw_en;
  logic sclk_rise, sclk_fall, scl_rise, scl_fall, tw_start, tw_stop;

  assign cs_n_s    = sync_r[shp_pkg::SY_CS];
  assign port_spi  = sync_r[shp_pkg::SY_PSEL];
  assign spi_en    = port_spi & ~cs_n_s;  // R2 R24
  assign tw_en     = ~port_spi;           // R24
  assign sclk_rise = spi_en & sync_r[shp_pkg::SY_SCLK] & ~prev_r[shp_pkg::SY_SCLK];
  assign sclk_fall = spi_en & ~sync_r[shp_pkg::SY_SCLK] & prev_r[shp_pkg::SY_SCLK];
  assign scl_rise  = tw_en & sync_r[shp_pkg::SY_SCL] & ~prev_r[shp_pkg::SY_SCL];
  assign scl_fall  = tw_en & ~sync_r[shp_pkg::SY_SCL] & prev_r[shp_pkg::SY_SCL];
  assign tw_start  = tw_en & sync_r[shp_pkg::SY_SCL] & prev_r[shp_pkg::SY_SCL]
                   & ~sync_r[shp_pkg::SY_SDA] & prev_r[shp_pkg::SY_SDA];
  assign tw_stop   = tw_en & sync_r[shp_pkg::SY_SCL] & prev_r[shp_pkg::SY_SCL]
                   & sync_r[shp_pkg::SY_SDA] & ~prev_r[shp_pkg::SY_SDA];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // four-wire slave

  shp_pkg::shp_spi_state_t spi_state_r;
  logic [6:0] spi_cnt_r, spi_addr_r;
  logic [7:0] spi_sh_r;
  logic       spi_burst_r, spi_wr_r, spi_ld_go_r, spi_shift;
  logic [shp_pkg::BUF_W-1:0] buf_r;

  always_ff @(posedge CLK) begin
    if (!RST_N || !spi_en) begin  // R2 R3 R13
      spi_state_r <= shp_pkg::SP_IDLE;
      spi_cnt_r   <= '0;
      spi_sh_r    <= '0;
      spi_addr_r  <= '0;
      spi_burst_r <= 1'b0;
      spi_wr_r    <= 1'b0;
      spi_ld_go_r <= 1'b0;
    end else begin
      spi_wr_r    <= 1'b0;
      spi_ld_go_r <= 1'b0;
      unique case (spi_state_r)
        shp_pkg::SP_IDLE: spi_state_r <= shp_pkg::SP_ADDR;
        shp_pkg::SP_ADDR: if (sclk_rise) begin  // R7
          spi_sh_r  <= {spi_sh_r[6:0], sync_r[shp_pkg::SY_MOSI]};
          spi_cnt_r <= spi_cnt_r + 7'h01;
          if (spi_cnt_r == shp_pkg::SPI_ADDR_LAST) begin
            spi_addr_r <= {spi_sh_r[5:0], sync_r[shp_pkg::SY_MOSI]};
            if (spi_sh_r[6]) begin
              spi_state_r <= shp_pkg::SP_WDATA;  // R5
            end else begin
              spi_state_r <= shp_pkg::SP_RDATA;  // R6
              spi_ld_go_r <= 1'b1;               // R14
              spi_burst_r <= BURST_MODE
                & ({spi_sh_r[5:0], sync_r[shp_pkg::SY_MOSI]} == shp_pkg::MOTION_ADDR);  // R11 R12
            end
          end
        end
        shp_pkg::SP_WDATA: if (sclk_rise) begin
          spi_sh_r  <= {spi_sh_r[6:0], sync_r[shp_pkg::SY_MOSI]};
          spi_cnt_r <= spi_cnt_r + 7'h01;
          if (spi_cnt_r == shp_pkg::SPI_BYTE2_LAST) begin
            spi_wr_r    <= 1'b1;  // R5
            spi_cnt_r   <= '0;
            spi_state_r <= shp_pkg::SP_ADDR;
          end
        end
        shp_pkg::SP_RDATA: if (sclk_rise) begin
          spi_cnt_r <= spi_cnt_r + 7'h01;
          if (spi_burst_r && spi_cnt_r == shp_pkg::SPI_BURST_LAST) begin
            spi_state_r <= shp_pkg::SP_DONE;  // R15
          end else if (!spi_burst_r && spi_cnt_r == shp_pkg::SPI_BYTE2_LAST) begin
            spi_cnt_r   <= '0;
            spi_state_r <= shp_pkg::SP_ADDR;
          end
        end
        shp_pkg::SP_DONE: spi_state_r <= shp_pkg::SP_DONE;  // R15
      endcase
    end
  end

  assign spi_shift = sclk_fall & (spi_state_r == shp_pkg::SP_RDATA);  // R7 R14

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MISO_O  <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= spi_en;  // R2
      if (spi_shift) begin
        MISO_O <= buf_r[shp_pkg::BUF_W-1];  // R7 R8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // two-wire slave

  shp_pkg::shp_tw_state_t tw_state_r;
  logic [2:0] tw_cnt_r;
  logic [7:0] tw_sh_r, tw_byte;
  logic [6:0] tw_reg_r, tw_slave;
  logic       tw_full_r, tw_rd_r, tw_ai_r, tw_nak_r, tw_wr_r, tw_ld_go_r, tw_shift, tw_rx;

  assign tw_slave = shp_pkg::TW_ADDR_BASE
                  | {5'h00, sync_r[shp_pkg::SY_SEL1], sync_r[shp_pkg::SY_SEL0]};  // R16
  assign tw_byte  = {tw_sh_r[6:0], sync_r[shp_pkg::SY_SDA]};
  assign tw_rx    = (tw_state_r == shp_pkg::TW_DEV) | (tw_state_r == shp_pkg::TW_REG)
                  | (tw_state_r == shp_pkg::TW_WDATA);
  assign SDA_O    = 1'b0;

  always_ff @(posedge CLK) begin
    if (!RST_N || !tw_en) begin
      tw_state_r <= shp_pkg::TW_IDLE;
      tw_cnt_r   <= '0;
      tw_sh_r    <= '0;
      tw_reg_r   <= '0;
      tw_full_r  <= 1'b0;
      tw_rd_r    <= 1'b0;
      tw_ai_r    <= 1'b0;
      tw_nak_r   <= 1'b0;
      tw_wr_r    <= 1'b0;
      tw_ld_go_r <= 1'b0;
      SDA_OE     <= 1'b0;
    end else begin
      tw_wr_r    <= 1'b0;
      tw_ld_go_r <= 1'b0;
      if (tw_start) begin  // R25
        tw_state_r <= shp_pkg::TW_DEV;
        tw_cnt_r   <= '0;
        tw_full_r  <= 1'b0;
        SDA_OE     <= 1'b0;
      end else if (tw_stop) begin  // R17
        tw_state_r <= shp_pkg::TW_IDLE;
        SDA_OE     <= 1'b0;
      end else if (tw_rx && scl_rise) begin  // R20
        tw_sh_r  <= tw_byte;
        tw_cnt_r <= tw_cnt_r + 3'h1;
        if (tw_cnt_r == shp_pkg::TW_BIT_LAST) begin
          tw_full_r <= 1'b1;
          if (tw_state_r == shp_pkg::TW_DEV) begin  // R21
            tw_rd_r <= tw_byte[0];
            if (tw_byte[7:1] != tw_slave) begin
              tw_state_r <= shp_pkg::TW_IDLE;  // R16
            end else if (tw_byte[0]) begin
              tw_ld_go_r <= 1'b1;
            end
          end else if (tw_state_r == shp_pkg::TW_REG) begin  // R22
            tw_ai_r  <= tw_byte[7];
            tw_reg_r <= tw_byte[6:0];
          end else begin
            tw_wr_r <= 1'b1;
          end
        end
      end else if (tw_rx && scl_fall && tw_full_r) begin  // R19
        tw_full_r  <= 1'b0;
        tw_cnt_r   <= '0;
        SDA_OE     <= 1'b1;
        tw_state_r <= (tw_state_r == shp_pkg::TW_DEV) ? shp_pkg::TW_DEV_ACK
                    : (tw_state_r == shp_pkg::TW_REG) ? shp_pkg::TW_REG_ACK : shp_pkg::TW_W_ACK;
      end else begin
        unique case (tw_state_r)
          shp_pkg::TW_DEV_ACK, shp_pkg::TW_REG_ACK, shp_pkg::TW_W_ACK: if (scl_fall) begin  // R18
            SDA_OE <= 1'b0;
            if (tw_state_r == shp_pkg::TW_DEV_ACK && tw_rd_r) begin
              tw_state_r <= shp_pkg::TW_RDATA;
              SDA_OE     <= ~buf_r[shp_pkg::BUF_W-1];
            end else if (tw_state_r == shp_pkg::TW_DEV_ACK) begin
              tw_state_r <= shp_pkg::TW_REG;
            end else begin
              tw_state_r <= shp_pkg::TW_WDATA;
              if (tw_state_r == shp_pkg::TW_W_ACK) begin
                tw_reg_r <= tw_reg_r + {6'h00, tw_ai_r};  // R22
              end
            end
          end
          shp_pkg::TW_RDATA: if (scl_rise) begin
            tw_cnt_r <= tw_cnt_r + 3'h1;
            tw_full_r <= (tw_cnt_r == shp_pkg::TW_BIT_LAST);
          end else if (scl_fall && tw_full_r) begin
            tw_full_r  <= 1'b0;
            tw_cnt_r   <= '0;
            SDA_OE     <= 1'b0;  // R19
            tw_state_r <= shp_pkg::TW_R_ACK;
          end else if (scl_fall) begin
            SDA_OE <= ~buf_r[shp_pkg::BUF_W-2];  // R20
          end
          shp_pkg::TW_R_ACK: if (scl_rise) begin  // R23
            tw_nak_r <= sync_r[shp_pkg::SY_SDA];
            if (!sync_r[shp_pkg::SY_SDA]) begin
              tw_reg_r   <= tw_reg_r + {6'h00, tw_ai_r};  // R22
              tw_ld_go_r <= 1'b1;
            end
          end else if (scl_fall) begin
            tw_state_r <= tw_nak_r ? shp_pkg::TW_IDLE : shp_pkg::TW_RDATA;
            SDA_OE     <= ~tw_nak_r & ~buf_r[shp_pkg::BUF_W-1];
          end
          default: tw_state_r <= tw_state_r;
        endcase
      end
    end
  end

  assign tw_shift = scl_fall & ~tw_start & ~tw_stop & ~tw_full_r & (tw_state_r == shp_pkg::TW_RDATA);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // register fetch into the output buffer, write stage, burst mode

  logic                    ld_busy_r, ld_burst_r, ld_wr_v_r;
  logic [2:0]              ld_idx_r, ld_wr_idx_r, ld_last;
  logic [6:0]              ld_raddr;
  logic [7:0]              mem_rdata;

  assign ld_last  = ld_burst_r ? shp_pkg::LD_BURST_LAST : 3'h0;
  assign ld_raddr = ld_burst_r ? shp_pkg::burst_addr(ld_idx_r) : (port_spi ? spi_addr_r : tw_reg_r);  // R12

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ld_busy_r   <= 1'b0;
      ld_burst_r  <= 1'b0;
      ld_idx_r    <= '0;
      ld_wr_v_r   <= 1'b0;
      ld_wr_idx_r <= '0;
    end else begin
      ld_wr_v_r   <= ld_busy_r;
      ld_wr_idx_r <= ld_idx_r;
      if (spi_ld_go_r || tw_ld_go_r) begin  // R14
        ld_busy_r  <= 1'b1;
        ld_idx_r   <= '0;
        ld_burst_r <= spi_ld_go_r & spi_burst_r;
      end else if (ld_busy_r) begin
        ld_idx_r  <= ld_idx_r + 3'h1;
        ld_busy_r <= (ld_idx_r != ld_last);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      buf_r <= '0;
    end else if (ld_wr_v_r) begin
      buf_r[shp_pkg::BUF_W-1-8*int'(ld_wr_idx_r) -: 8] <= mem_rdata;  // R14
    end else if (spi_shift || tw_shift) begin
      buf_r <= {buf_r[shp_pkg::BUF_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_WR_PULSE <= 1'b0;
      REG_WR_ADDR  <= '0;
      REG_WR_DATA  <= '0;
      BURST_MODE   <= 1'b0;
    end else begin
      REG_WR_PULSE <= spi_wr_r | tw_wr_r;
      REG_WR_ADDR  <= spi_wr_r ? spi_addr_r : tw_reg_r;
      REG_WR_DATA  <= spi_wr_r ? spi_sh_r : tw_sh_r;
      if (REG_WR_PULSE && REG_WR_ADDR == shp_pkg::IO_MODE_ADDR) begin
        BURST_MODE <= (REG_WR_DATA == shp_pkg::BURST_ENABLE);  // R11
      end
    end
  end

  shp_regmem #(.AW(shp_pkg::REG_AW), .DW(shp_pkg::REG_DW)) u_mem (
    .clk   (CLK),
    .rst_n (RST_N),
    .we    (REG_WR_PULSE),
    .waddr (REG_WR_ADDR),
    .wdata (REG_WR_DATA),
    .re    (ld_busy_r),
    .raddr (ld_raddr),
    .rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_only_on_host_edge;
    spi_ld_go_r |-> $past(sclk_rise);
  endproperty
  a_only_on_host_edge: assert property (p_only_on_host_edge) else $error("fetch without host clock edge"); // R1

  property p_release_unselected;
    cs_n_s |=> !MISO_OE;
  endproperty
  a_release_unselected: assert property (p_release_unselected) else $error("serial output driven unselected"); // R2

  property p_abort_on_deselect;
    $rose(cs_n_s) |=> (spi_state_r == shp_pkg::SP_IDLE) && (spi_cnt_r == 7'h00);
  endproperty
  a_abort_on_deselect: assert property (p_abort_on_deselect) else $error("deselect did not abort"); // R3

  property p_write_commits;
    (spi_state_r == shp_pkg::SP_WDATA) && sclk_rise && (spi_cnt_r == shp_pkg::SPI_BYTE2_LAST)
      |=> ##1 REG_WR_PULSE && (REG_WR_ADDR == $past(spi_addr_r, 2));
  endproperty
  a_write_commits: assert property (p_write_commits) else $error("serial write not committed"); // R5

  property p_out_on_fall;
    !$past(spi_shift) |-> $stable(MISO_O);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("data out changed off falling clock"); // R7

  property p_burst_enable;
    REG_WR_PULSE && (REG_WR_ADDR == shp_pkg::IO_MODE_ADDR) && (REG_WR_DATA == shp_pkg::BURST_ENABLE)
      |=> BURST_MODE;
  endproperty
  a_burst_enable: assert property (p_burst_enable) else $error("burst mode not enabled"); // R11

  property p_burst_fetch;
    spi_ld_go_r && spi_burst_r |=> ld_busy_r [*7] ##1 !ld_busy_r;
  endproperty
  a_burst_fetch: assert property (p_burst_fetch) else $error("burst fetch not seven registers"); // R12

  property p_burst_lock;
    (spi_state_r == shp_pkg::SP_DONE) && spi_en |=> spi_state_r == shp_pkg::SP_DONE;
  endproperty
  a_burst_lock: assert property (p_burst_lock) else $error("port left burst lock"); // R15

  property p_addr_mismatch;
    (tw_state_r == shp_pkg::TW_DEV) && scl_rise && !tw_start && !tw_stop
      && (tw_cnt_r == shp_pkg::TW_BIT_LAST) && (tw_byte[7:1] != tw_slave) |=> tw_state_r == shp_pkg::TW_IDLE;
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch) else $error("foreign address answered"); // R16

  property p_sda_drive;
    SDA_OE |-> tw_state_r inside {shp_pkg::TW_DEV_ACK, shp_pkg::TW_REG_ACK, shp_pkg::TW_W_ACK, shp_pkg::TW_RDATA};
  endproperty
  a_sda_drive: assert property (p_sda_drive) else $error("data line driven outside ack or read"); // R18

  property p_start_restarts;
    tw_start |=> (tw_state_r == shp_pkg::TW_DEV) && (tw_cnt_r == 3'h0) && !SDA_OE;
  endproperty
  a_start_restarts: assert property (p_start_restarts) else $error("start did not restart packet"); // R25

  c_burst_done: cover property (spi_state_r == shp_pkg::SP_DONE);
  c_spi_abort: cover property ((spi_state_r == shp_pkg::SP_RDATA) && $rose(cs_n_s));
  c_tw_read: cover property ((tw_state_r == shp_pkg::TW_R_ACK) && scl_rise && !sync_r[shp_pkg::SY_SDA]);
  c_tw_write: cover property (tw_wr_r);

endmodule // shp_host_port

// ===== tb/shp_host_model.sv
// shp_host_model: host microcontroller driving the four-wire and two-wire ports.
// assumes clk is the sensor core clock; every pin change lands 1 ns after a rising edge.
`timescale 1ns/1ps
module shp_host_model (
  input  wire logic clk,      // core clock
  output logic      cs_n,     // chip select, active low
  output logic      sclk,     // serial clock, idles high
  output logic      mosi,     // serial data to sensor
  input  wire logic miso_o,   // sensor data
  input  wire logic miso_oe,  // sensor drive enable
  output logic      scl,      // two-wire clock
  output logic      sda,      // two-wire line level
  input  wire logic sda_oe    // sensor pulls low
);
  logic hd = 1'b0;  // host pulls sda low
  logic ml = 1'b0;  // last miso level seen
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
    scl  = 1'b1;
  end
  assign sda = ~(hd | sda_oe);
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // released mosi flips so a stale level is never mistaken for data
  task automatic sel(input logic v);
    tk(4);
    cs_n = v;
    mosi = ~mosi;
    tk(4);
  endtask
  task automatic spi(input logic [7:0] o, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) begin
      sclk = 1'b0;
      mosi = o[k];
      tk(4);
      sclk = 1'b1;
      ml = miso_oe ? miso_o : ~ml;
      r[k] = ml;
      tk(4);
    end
  endtask
  task automatic tbit(input logic b, output logic r);
    hd = ~b;
    tk(8);
    scl = 1'b1;
    tk(8);
    r = sda;
    scl = 1'b0;
    tk(2);
  endtask
  task automatic st;
    hd = 1'b0;
    tk(8);
    scl = 1'b1;
    tk(8);
    hd = 1'b1;
    tk(8);
    scl = 1'b0;
    tk(8);
  endtask
  task automatic sp;
    hd = 1'b1;
    tk(8);
    scl = 1'b1;
    tk(8);
    hd = 1'b0;
    tk(8);
  endtask
  task automatic twb(input logic [7:0] b, input logic ak, output logic [7:0] r, output logic a);
    for (int k = 7; k >= 0; k--) tbit(b[k], r[k]);
    tbit(ak, a);
  endtask
endmodule // shp_host_model

// ===== tb/tb.sv
// tb: self-checking bench for the sensor host serial port.
// assumes the host model drives every link pin; tb drives reset, port select and address pins.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b1, cs_n, sclk, mosi, miso_o, miso_oe, scl, sda, sda_o, sda_oe;
  logic bm, wp, a;
  logic [1:0] sa = 2'b11;
  logic [6:0] wa;
  logic [7:0] wd, r;
  logic [6:0] ord [7] = '{7'h02, 7'h04, 7'h03, 7'h05, 7'h06, 7'h07, 7'h08};
  int failures = 0, num_checks = 0, wcnt = 0;
  initial forever #25 clk = ~clk;
  shp_host_port uut (.CLK(clk), .RST_N(rst_n), .PORT_SEL(psel), .SERIAL_SELECT_N(cs_n), .SCLK(sclk),
    .MOSI(mosi), .MISO_O(miso_o), .MISO_OE(miso_oe), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SLAVE_ADDR_SEL0(sa[0]), .SLAVE_ADDR_SEL1(sa[1]), .BURST_MODE(bm),
    .REG_WR_PULSE(wp), .REG_WR_ADDR(wa), .REG_WR_DATA(wd));
  shp_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe), .scl(scl), .sda(sda), .sda_oe(sda_oe));
  always @(posedge clk) if (wp === 1'b1) wcnt <= wcnt + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    host.sel(1'b0);
    fork
      begin
        host.spi({1'b1, ad}, r);
        host.spi(d, r);
      end
      begin
        @(posedge wp);
        #1;
        chk({1'b0, wa}, {1'b0, ad});
        chk(wd, d);
      end
    join
    host.sel(1'b1);
    host.tk(20);
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] e);
    host.sel(1'b0);
    host.spi({1'b0, ad}, r);
    host.tk(16);
    host.spi(8'h00, r);
    chk(r, e);
    host.sel(1'b1);
    host.tk(20);
  endtask
  task automatic t_spi;
    chk({3'h0, sda_o, miso_oe, sda_oe, bm, wp}, 8'h00);
    host.sel(1'b0);
    chk({7'h00, miso_oe}, 8'h01);
    host.sel(1'b1);
    chk({7'h00, miso_oe}, 8'h00);
    wr(7'h0B, 8'hA5);
    rd(7'h0B, 8'hA5);
    host.sel(1'b0);
    host.spi(8'h8A, r);
    host.sel(1'b1);
    host.tk(20);
    wr(7'h0A, 8'h3C);
    rd(7'h0A, 8'h3C);
    $display("t_spi done");
  endtask
  task automatic t_burst(input int n);
    int c;
    host.sel(1'b0);
    host.spi(8'h02, r);
    host.tk(16);
    for (int k = 0; k < n; k++) begin
      host.spi(8'h00, r);
      chk(r, 8'h20 + {1'b0, ord[k]});
    end
    c = wcnt;
    if (n == 7) begin
      host.spi(8'h8C, r);
      host.spi(8'h55, r);
    end
    host.sel(1'b1);
    host.tk(20);
    if (n == 7) chk(8'(wcnt), 8'(c));
    $display("t_burst done");
  endtask
  task automatic t_twi;
    psel = 1'b0;
    host.tk(8);
    host.st();
    host.twb(8'hAE, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    host.twb(8'h90, 1'b1, r, a);
    host.twb(8'h66, 1'b1, r, a);
    host.twb(8'h77, 1'b1, r, a);
    host.sp();
    chk(8'(wcnt), 8'(13));
    host.st();
    host.twb(8'hAE, 1'b1, r, a);
    host.twb(8'h90, 1'b1, r, a);
    host.st();
    host.twb(8'hAF, 1'b1, r, a);
    host.twb(8'hFF, 1'b0, r, a);
    chk(r, 8'h66);
    host.twb(8'hFF, 1'b1, r, a);
    chk(r, 8'h77);
    host.sp();
    sa = 2'b00;
    host.st();
    host.twb(8'hAE, 1'b1, r, a);
    chk({6'h00, a, sda_oe}, 8'h02);
    host.sp();
    host.st();
    host.twb(8'hA8, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    host.sp();
    $display("t_twi done");
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    host.tk(4);
    t_spi();
    for (int k = 0; k < 7; k++) wr(ord[k], 8'h20 + {1'b0, ord[k]});
    wr(7'h1C, 8'h10);
    chk({7'h00, bm}, 8'h01);
    t_burst(3);
    t_burst(7);
    wr(7'h1C, 8'h00);
    chk({7'h00, bm}, 8'h00);
    t_twi();
    finish_test();
  end
endmodule // tb
